// ===== hw/smt_signal_monitor.sv
// Register bank and control logic for data-reception signal monitoring and wakeup timeout
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Bits 6..1 of monitor control select which monitors run during data reception.
// - An enabled monitor failure during data reception raises the end-of-frame flag.
// - Accumulate bit set collects monitor errors over the whole reception.
// - Error accumulator clears at reception start and on status sampling.
// - Wakeup timeout equals count times prescaled unit for counts 1 to 63.
// - Count zero disables the wakeup timeout; it never expires.
// - Prescaler codes give unit of 2, 4, 16 or 64 bit periods.
// - Low threshold register holds captured threshold LSBs, readable by software.
// - Threshold registers accept writes to restore a saved value.
// - Captured initial threshold stays separate from the applied slicer threshold.
// - High threshold register holds captured threshold MSBs.
// - Observation length codes give 8, 16, 24 or 32 observed bits.
// - Summed error limit per 8 bits is 16..192 chip/128 by code.
// - Single-chip check accepts an interval only if its error is below limit.
// - Single-chip limit codes give 16, 24, 32 or 48 chip/128.
// - Monitor bits 6..1: chip timeout, timing, coding, baud, level, modulation.
// - Optimistic mode: timeout expiry fails the search unless all monitors passed.
// - Preamble-timeout enable makes the same timeout bound preamble detection.
module smt_signal_monitor
	import smt_pkg::*;
#(
	parameter int THRESH_W = 16
) (
	input  wire logic                    mclk_i,
	input  wire logic                    arst_n_i,
	input  wire logic                    ce_i,
	input  wire smt_reg_req_s            reg_req_i,
	output logic [7:0]                   reg_rdata_o,
	output logic                         reg_rvalid_o,
	input  wire logic                    rx_active_i,
	input  wire logic                    rx_start_i,
	input  wire logic                    status_sample_i,
	input  wire logic [SMT_NMON-1:0]     mon_fail_i,
	output logic                         eof_flag_o,
	output logic [SMT_NMON-1:0]          mon_err_o,
	output logic [SMT_NMON-1:0]          mon_run_o,
	input  wire logic                    bit_tick_i,
	input  wire logic                    search_start_i,
	input  wire logic                    search_active_i,
	input  wire logic                    preamble_start_i,
	input  wire logic                    preamble_active_i,
	input  wire logic                    preamble_timeout_enable_i,
	input  wire logic                    wakeup_search_policy_i,
	input  wire logic                    all_pass_i,
	output logic                         timeout_o,
	output logic                         search_fail_o,
	input  wire logic                    thresh_capture_i,
	input  wire logic [THRESH_W-1:0]     thresh_capture_val_i,
	output logic [THRESH_W-1:0]          init_thresh_o,
	input  wire smt_interval_s           interval_i,
	output logic                         chip_ok_o,
	output logic                         chip_bad_o,
	output logic                         baud_done_o,
	output logic                         baud_ok_o
);

	initial begin
		if (THRESH_W <= 8 || THRESH_W > 16) begin
			$error("smt_signal_monitor: THRESH_W must be 9..16");
		end
		if (SMT_MON_SEL_LSB + SMT_NMON > 8 || SMT_TCK_OBS_LSB + 2 > 8) begin
			$error("smt_signal_monitor: field layout does not fit the 8-bit registers");
		end
	end

	typedef struct packed {
		logic [7:0]          mon_ctrl;
		logic [7:0]          to_ctrl;
		logic [7:0]          thl;
		logic [7:0]          thh;
		logic [7:0]          tck_ctrl;
		logic [7:0]          rdata;
		logic                rvalid;
		logic                eof;
		logic [SMT_NMON-1:0] err_bits;
		logic [5:0]          presc_cnt;
		logic [5:0]          unit_cnt;
		logic                expired;
		logic                timeout;
		logic                search_fail;
	} smt_state_s;

	smt_state_s st;
	smt_state_s next_st;

	logic [SMT_NMON-1:0] mon_sel;
	logic                accumulate;
	logic [SMT_NMON-1:0] hit;
	logic [5:0]          to_count;
	logic [6:0]          presc_len;
	logic                to_run;
	logic [6:0]          presc_inc;
	logic [6:0]          unit_inc;
	logic [15:0]         thresh_full;
	smt_tck_cfg_s        tck_cfg;
	logic [4:0]          sel;

	// One-hot select of the addressed register; write and read paths share it
	// so the two decoders cannot drift apart
	function automatic logic [4:0] reg_sel(input logic [7:0] addr);
		if (addr == SMT_ADDR_MON) begin
			reg_sel = 5'h01;
		end else if (addr == SMT_ADDR_TO) begin
			reg_sel = 5'h02;
		end else if (addr == SMT_ADDR_THL) begin
			reg_sel = 5'h04;
		end else if (addr == SMT_ADDR_THH) begin
			reg_sel = 5'h08;
		end else if (addr == SMT_ADDR_TCK) begin
			reg_sel = 5'h10;
		end else begin
			reg_sel = 5'h00;
		end
	endfunction

	// Field extraction from the stored registers
	always_comb begin
		mon_sel    = st.mon_ctrl[SMT_MON_SEL_LSB +: SMT_NMON];
		accumulate = st.mon_ctrl[SMT_MON_ACC_BIT];
		to_count   = st.to_ctrl[SMT_TO_CNT_LSB +: 6];
		presc_len  = smt_presc_len(st.to_ctrl[SMT_TO_PRE_LSB +: 2]);
		tck_cfg.obs = st.tck_ctrl[SMT_TCK_OBS_LSB +: 2];
		tck_cfg.sum = st.tck_ctrl[SMT_TCK_SUM_LSB +: 3];
		tck_cfg.sgl = st.tck_ctrl[SMT_TCK_SGL_LSB +: 2];
		// Monitor index 0 is enable bit 1 (modulation amplitude), index 5 is bit 6
		hit        = mon_fail_i & mon_sel & {SMT_NMON{rx_active_i}};
		// Preamble detection shares the wakeup timer only when enabled
		to_run     = search_active_i | (preamble_active_i & preamble_timeout_enable_i);
		presc_inc  = {1'b0, st.presc_cnt} + 7'h01;
		unit_inc   = {1'b0, st.unit_cnt} + 7'h01;
		thresh_full = 16'(thresh_capture_val_i);
		sel         = reg_sel(reg_req_i.addr);
	end

	always_comb begin
		next_st             = st;
		next_st.rvalid      = 1'b0;
		next_st.timeout     = 1'b0;
		next_st.search_fail = 1'b0;

		// Register writes; reserved bits are masked off
		if (reg_req_i.wr) begin
			if (sel[0]) begin
				next_st.mon_ctrl = reg_req_i.wdata & SMT_MASK_MON;
			end else if (sel[1]) begin
				next_st.to_ctrl = reg_req_i.wdata & SMT_MASK_TO;
			end else if (sel[2]) begin
				next_st.thl = reg_req_i.wdata;
			end else if (sel[3]) begin
				next_st.thh = reg_req_i.wdata & 8'((16'h1 << (THRESH_W - 8)) - 16'h1);
			end else if (sel[4]) begin
				next_st.tck_ctrl = reg_req_i.wdata & SMT_MASK_TCK;
			end
		end

		// Hardware capture at slicer init wins over a same-cycle write
		if (thresh_capture_i) begin
			next_st.thl = thresh_full[7:0];
			next_st.thh = thresh_full[15:8];
		end

		// Reads return stored values one cycle later; unmapped reads give zero
		if (reg_req_i.rd) begin
			next_st.rvalid = 1'b1;
			if (sel[0]) begin
				next_st.rdata = st.mon_ctrl;
			end else if (sel[1]) begin
				next_st.rdata = st.to_ctrl;
			end else if (sel[2]) begin
				next_st.rdata = st.thl;
			end else if (sel[3]) begin
				next_st.rdata = st.thh;
			end else if (sel[4]) begin
				next_st.rdata = st.tck_ctrl;
			end else begin
				next_st.rdata = 8'h00;
			end
		end

		// Error indication: clears first, so an event in the same cycle survives
		if (rx_start_i || status_sample_i) begin
			next_st.err_bits = '0;
			next_st.eof      = 1'b0;
		end
		if (|hit) begin
			if (accumulate) begin
				next_st.err_bits = next_st.err_bits | hit;
			end else begin
				next_st.err_bits = hit;
			end
			next_st.eof = 1'b1;
		end

		// Wakeup search timeout: restart wins over counting
		if (search_start_i || preamble_start_i) begin
			next_st.presc_cnt = 6'h00;
			next_st.unit_cnt  = 6'h00;
			next_st.expired   = 1'b0;
		end else if (to_run && to_count != 6'h00 && !st.expired && bit_tick_i) begin
			if (presc_inc >= presc_len) begin
				next_st.presc_cnt = 6'h00;
				if (unit_inc >= {1'b0, to_count}) begin
					next_st.unit_cnt = 6'h00;
					next_st.expired  = 1'b1;
					next_st.timeout  = 1'b1;
					// Optimistic policy ends a search with FAIL unless all passed
					if (search_active_i && wakeup_search_policy_i && !all_pass_i) begin
						next_st.search_fail = 1'b1;
					end
				end else begin
					next_st.unit_cnt = unit_inc[5:0];
				end
			end else begin
				next_st.presc_cnt = presc_inc[5:0];
			end
		end
	end

	// Register state; clock enable low freezes everything
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st          <= '0;
			st.mon_ctrl <= SMT_RST_REG;
			st.to_ctrl  <= SMT_RST_REG;
			st.thl      <= SMT_RST_REG;
			st.thh      <= SMT_RST_REG;
			st.tck_ctrl <= SMT_RST_REG;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	smt_timing_check #(
		.ERR_W (SMT_ERR_W)
	) smt_timing_check_i (
		.mclk_i      (mclk_i),
		.arst_n_i    (arst_n_i),
		.ce_i        (ce_i),
		.cfg_i       (tck_cfg),
		.rx_active_i (rx_active_i),
		.bit_tick_i  (bit_tick_i),
		.interval_i  (interval_i),
		.chip_ok_o   (chip_ok_o),
		.chip_bad_o  (chip_bad_o),
		.baud_done_o (baud_done_o),
		.baud_ok_o   (baud_ok_o)
	);

	// The captured value is only a starting point; the slicer's live threshold
	// is held elsewhere and never read back through these registers
	assign init_thresh_o = {st.thh[THRESH_W-9:0], st.thl};
	assign reg_rdata_o   = st.rdata;
	assign reg_rvalid_o  = st.rvalid;
	assign eof_flag_o    = st.eof;
	assign mon_err_o     = st.err_bits;
	assign mon_run_o     = mon_sel & {SMT_NMON{rx_active_i}} & {SMT_NMON{1'b1}};
	assign timeout_o     = st.timeout;
	assign search_fail_o = st.search_fail;

endmodule
`default_nettype wire

// ===== hw/smt_pkg.sv
// Package: register map, field layout and lookup functions of the signal monitor block
package smt_pkg;

	localparam logic [7:0] SMT_ADDR_MON  = 8'h30;
	localparam logic [7:0] SMT_ADDR_TO   = 8'h31;
	localparam logic [7:0] SMT_ADDR_THL  = 8'h32;
	localparam logic [7:0] SMT_ADDR_THH  = 8'h33;
	localparam logic [7:0] SMT_ADDR_TCK  = 8'h34;

	// Writable bits per register; the rest are reserved and read zero
	localparam logic [7:0] SMT_MASK_MON  = 8'h7f;
	localparam logic [7:0] SMT_MASK_TO   = 8'hff;
	localparam logic [7:0] SMT_MASK_TCK  = 8'h7f;

	localparam logic [7:0] SMT_RST_REG   = 8'h00;

	localparam int SMT_MON_ACC_BIT   = 0;
	localparam int SMT_MON_SEL_LSB   = 1;
	localparam int SMT_TO_CNT_LSB    = 0;
	localparam int SMT_TO_PRE_LSB    = 6;
	localparam int SMT_TCK_SGL_LSB   = 0;
	localparam int SMT_TCK_SUM_LSB   = 2;
	localparam int SMT_TCK_OBS_LSB   = 5;

	localparam int SMT_NMON          = 6;
	localparam int SMT_ERR_W         = 10;
	localparam int SMT_BITS_PER_STEP = 8;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} smt_reg_req_s;

	typedef struct packed {
		logic                        valid;
		logic signed [SMT_ERR_W-1:0] err;
	} smt_interval_s;

	typedef struct packed {
		logic [1:0] obs;
		logic [2:0] sum;
		logic [1:0] sgl;
	} smt_tck_cfg_s;

	// Bit periods per timeout unit
	function automatic logic [6:0] smt_presc_len(input logic [1:0] code);
		case (code)
			2'h0:    smt_presc_len = 7'h02;
			2'h1:    smt_presc_len = 7'h04;
			2'h2:    smt_presc_len = 7'h10;
			default: smt_presc_len = 7'h40;
		endcase
	endfunction

	// Summed error limit per 8 bits, in chip time / 128
	function automatic logic [7:0] smt_sum_limit(input logic [2:0] code);
		case (code)
			3'h0:    smt_sum_limit = 8'h10;
			3'h1:    smt_sum_limit = 8'h18;
			3'h2:    smt_sum_limit = 8'h20;
			3'h3:    smt_sum_limit = 8'h30;
			3'h4:    smt_sum_limit = 8'h40;
			3'h5:    smt_sum_limit = 8'h60;
			3'h6:    smt_sum_limit = 8'h80;
			default: smt_sum_limit = 8'hc0;
		endcase
	endfunction

	// Per-interval error limit, in chip time / 128
	function automatic logic [5:0] smt_single_limit(input logic [1:0] code);
		case (code)
			2'h0:    smt_single_limit = 6'h10;
			2'h1:    smt_single_limit = 6'h18;
			2'h2:    smt_single_limit = 6'h20;
			default: smt_single_limit = 6'h30;
		endcase
	endfunction

endpackage

// ===== hw/smt_timing_check.sv
// Timing-check units: single-chip interval check and baud-rate summed-error check
`timescale 1ns/10ps
`default_nettype none
module smt_timing_check
	import smt_pkg::*;
#(
	parameter int ERR_W = SMT_ERR_W
) (
	input  wire logic          mclk_i,
	input  wire logic          arst_n_i,
	input  wire logic          ce_i,
	input  wire smt_tck_cfg_s  cfg_i,
	input  wire logic          rx_active_i,
	input  wire logic          bit_tick_i,
	input  wire smt_interval_s interval_i,
	output logic               chip_ok_o,
	output logic               chip_bad_o,
	output logic               baud_done_o,
	output logic               baud_ok_o
);

	initial begin
		if (ERR_W != SMT_ERR_W) $error("smt_timing_check: ERR_W must match carrier width");
	end

	typedef struct packed {
		logic [5:0]  bit_cnt;
		logic [11:0] sum;
		logic        chip_ok;
		logic        chip_bad;
		logic        baud_done;
		logic        baud_ok;
	} smt_tck_state_s;

	smt_tck_state_s st;
	smt_tck_state_s next_st;

	logic [ERR_W-1:0] mag;
	logic [12:0]      sum_ext;
	logic [5:0]       obs_bits;
	logic [9:0]       total_limit;

	always_comb begin
		mag         = interval_i.err[ERR_W-1] ? ERR_W'(-interval_i.err) : ERR_W'(interval_i.err);
		sum_ext     = {1'b0, st.sum} + 13'(mag);
		obs_bits    = 6'({4'h0, cfg_i.obs} + 6'h1) * 6'(SMT_BITS_PER_STEP);
		total_limit = 10'(smt_sum_limit(cfg_i.sum)) * 10'({1'b0, cfg_i.obs} + 3'h1);
		next_st           = st;
		next_st.chip_ok   = 1'b0;
		next_st.chip_bad  = 1'b0;
		next_st.baud_done = 1'b0;
		if (!rx_active_i) begin
			next_st.bit_cnt = 6'h00;
			next_st.sum     = 12'h000;
		end else begin
			if (interval_i.valid) begin
				// Strictly below the limit is accepted
				if (mag < ERR_W'(smt_single_limit(cfg_i.sgl))) begin
					next_st.chip_ok = 1'b1;
				end else begin
					next_st.chip_bad = 1'b1;
				end
				// Saturate rather than wrap so a long burst of errors cannot pass
				next_st.sum = sum_ext[12] ? 12'hfff : sum_ext[11:0];
			end
			if (bit_tick_i) begin
				if (st.bit_cnt + 6'h01 >= obs_bits) begin
					next_st.baud_done = 1'b1;
					next_st.baud_ok   = next_st.sum <= 12'(total_limit);
					next_st.bit_cnt   = 6'h00;
					next_st.sum       = 12'h000;
				end else begin
					next_st.bit_cnt = st.bit_cnt + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign chip_ok_o   = st.chip_ok;
	assign chip_bad_o  = st.chip_bad;
	assign baud_done_o = st.baud_done;
	assign baud_ok_o   = st.baud_ok;

endmodule
`default_nettype wire

// ===== verification/smt_signal_monitor_checker.sv
// Concurrent checks on the ports of the signal monitor register bank
`timescale 1ns/10ps
`default_nettype none
module smt_signal_monitor_checker
	import smt_pkg::*;
#(
	parameter int THRESH_W = 16
) (
	input  wire logic                mclk_i,
	input  wire logic                arst_n_i,
	input  wire logic                ce_i,
	input  wire smt_reg_req_s        reg_req_i,
	input  wire logic                reg_rvalid_o,
	input  wire logic                rx_active_i,
	input  wire logic                rx_start_i,
	input  wire logic                status_sample_i,
	input  wire logic [SMT_NMON-1:0] mon_fail_i,
	input  wire logic [SMT_NMON-1:0] mon_run_o,
	input  wire logic                eof_flag_o,
	input  wire logic [SMT_NMON-1:0] mon_err_o,
	input  wire logic                bit_tick_i,
	input  wire logic                timeout_o,
	input  wire logic                search_fail_o,
	input  wire logic                thresh_capture_i,
	input  wire logic [THRESH_W-1:0] thresh_capture_val_i,
	input  wire logic [THRESH_W-1:0] init_thresh_o,
	input  wire smt_interval_s       interval_i,
	input  wire logic                chip_ok_o,
	input  wire logic                chip_bad_o
);
	logic [SMT_ERR_W-1:0] abs_err;
	logic                 thresh_wr;

	assign abs_err = interval_i.err[SMT_ERR_W-1] ? -interval_i.err : interval_i.err;
	assign thresh_wr = reg_req_i.wr && (reg_req_i.addr == SMT_ADDR_THL || reg_req_i.addr == SMT_ADDR_THH);

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_fail;
		ce_i && |(mon_fail_i & mon_run_o);
	endsequence
	sequence s_iv;
		ce_i && interval_i.valid && rx_active_i;
	endsequence

	a_read_answer: assert property (ce_i |=> reg_rvalid_o == $past(reg_req_i.rd))
		else $error("read answer pulse wrong");
	a_run_needs_rx: assert property (!rx_active_i |-> mon_run_o == '0)
		else $error("monitor runs outside reception");
	a_eof_on_fail: assert property (s_fail |=> eof_flag_o && (mon_err_o & $past(mon_fail_i & mon_run_o)) != '0)
		else $error("monitor failure not flagged");
	a_err_clear: assert property (ce_i && (rx_start_i || status_sample_i) && !(|(mon_fail_i & mon_run_o))
		|=> !eof_flag_o && mon_err_o == '0)
		else $error("error state not cleared");
	a_timeout_on_tick: assert property ($rose(timeout_o) |-> $past(bit_tick_i && ce_i))
		else $error("timeout without bit tick");
	a_fail_needs_exp: assert property (search_fail_o |-> timeout_o)
		else $error("search fail without expiry");
	a_capture_taken: assert property (ce_i && thresh_capture_i |=> init_thresh_o == $past(thresh_capture_val_i))
		else $error("threshold capture lost");
	a_thresh_hold: assert property (ce_i && !thresh_capture_i && !thresh_wr |=> $stable(init_thresh_o))
		else $error("threshold changed without cause");
	a_chip_one_result: assert property (s_iv |=> chip_ok_o != chip_bad_o)
		else $error("interval result not exactly one");
	a_chip_big_bad: assert property (s_iv ##0 (abs_err >= 10'h30) |=> chip_bad_o)
		else $error("large interval error accepted");
endmodule
`default_nettype wire

// ===== verification/smt_signal_monitor_test.sv
// Self-checking testbench of the signal monitor register bank
`timescale 1ns/10ps
`default_nettype none
module smt_signal_monitor_test
	import smt_pkg::*;
;
	localparam int         THRESH_W = 16;
	localparam int         PRE[4]   = '{2, 4, 16, 64};
	localparam int         SUM[8]   = '{16, 24, 32, 48, 64, 96, 128, 192};
	localparam int         SGL[4]   = '{16, 24, 32, 48};
	localparam logic [7:0] MSK[6]   = '{8'h7f, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h00};
	logic mclk_i, arst_n_i, ce_i, reg_rvalid_o, rx_active_i, rx_start_i, status_sample_i;
	logic eof_flag_o, bit_tick_i, search_start_i, search_active_i, preamble_start_i;
	logic preamble_active_i, preamble_timeout_enable_i, wakeup_search_policy_i, all_pass_i;
	logic timeout_o, search_fail_o, thresh_capture_i, chip_ok_o, chip_bad_o, baud_done_o, baud_ok_o;
	logic [7:0]          reg_rdata_o;
	logic [SMT_NMON-1:0] mon_fail_i, mon_err_o, mon_run_o;
	logic [THRESH_W-1:0] thresh_capture_val_i, init_thresh_o;
	smt_reg_req_s        reg_req_i;
	smt_interval_s       interval_i;
	int                  errors = 0;
	int                  checks = 0;

	smt_signal_monitor #(.THRESH_W(THRESH_W)) smt_signal_monitor_i (.*);

	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic step();
		@(posedge mclk_i);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_req_i = '{1'b1, 1'b0, a, d};
		step();
		reg_req_i = '0;
		step();
	endtask
	// Read data is checked together with its valid pulse, which stands one cycle only
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_req_i = '{1'b0, 1'b1, a, 8'h00};
		step();
		reg_req_i = '0;
		check({reg_rvalid_o, reg_rdata_o}, {1'b1, e});
		step();
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step();
		s = 1'b0;
		step();
	endtask
	task automatic fail(input logic [5:0] f, input logic [6:0] e);
		mon_fail_i = f;
		step();
		mon_fail_i = '0;
		check({eof_flag_o, mon_err_o}, e);
		step();
	endtask
	task automatic tk(input logic [2:0] e);
		bit_tick_i = 1'b1;
		step();
		bit_tick_i = 1'b0;
		check({timeout_o, search_fail_o, baud_done_o}, e);
		step();
	endtask
	task automatic iv(input int e, input int lim);
		interval_i = '{1'b1, 10'(e)};
		step();
		interval_i = '0;
		check({chip_ok_o, chip_bad_o}, (((e < 0) ? -e : e) < lim) ? 2'b10 : 2'b01);
		step();
	endtask

	initial begin
		#400000;
		errors++;
		conclude();
	end

	initial begin
		int e;
		{arst_n_i, rx_active_i, rx_start_i, status_sample_i, bit_tick_i, search_start_i} = '0;
		{search_active_i, preamble_start_i, preamble_active_i, preamble_timeout_enable_i} = '0;
		{wakeup_search_policy_i, all_pass_i, thresh_capture_i} = '0;
		ce_i = 1'b1;
		reg_req_i = '0;
		mon_fail_i = '0;
		thresh_capture_val_i = '0;
		interval_i = '0;
		repeat (4) @(posedge mclk_i);
		#1;
		arst_n_i = 1'b1;
		for (int a = 0; a < 6; a++) rd(8'h30 + 8'(a), 8'h00);
		for (int a = 0; a < 6; a++) wr(8'h30 + 8'(a), 8'hff);
		for (int a = 0; a < 6; a++) rd(8'h30 + 8'(a), MSK[a]);
		check(init_thresh_o, 16'hffff);
		// A frozen clock enable must swallow the write
		ce_i = 1'b0;
		wr(SMT_ADDR_TO, 8'h55);
		ce_i = 1'b1;
		rd(SMT_ADDR_TO, 8'hff);
		thresh_capture_val_i = 16'h5aa5;
		pulse(thresh_capture_i);
		rd(SMT_ADDR_THL, 8'ha5);
		rd(SMT_ADDR_THH, 8'h5a);
		check(init_thresh_o, 16'h5aa5);
		wr(SMT_ADDR_THL, 8'h3c);
		check(init_thresh_o, 16'h5a3c);
		rx_active_i = 1'b1;
		for (int i = 0; i < SMT_NMON; i++) begin
			wr(SMT_ADDR_MON, 8'(2 << i));
			fail(6'(1 << ((i + 1) % SMT_NMON)), 7'h00);
			fail(6'(1 << i), {1'b1, 6'(1 << i)});
			pulse(status_sample_i);
			check({eof_flag_o, mon_err_o}, 7'h00);
		end
		wr(SMT_ADDR_MON, 8'h7f);
		fail(6'h01, 7'h41);
		fail(6'h20, 7'h61);
		pulse(rx_start_i);
		check({eof_flag_o, mon_err_o}, 7'h00);
		wr(SMT_ADDR_MON, 8'h7e);
		check(mon_run_o, 6'h3f);
		fail(6'h01, 7'h41);
		fail(6'h20, 7'h60);
		rx_active_i = 1'b0;
		pulse(status_sample_i);
		fail(6'h3f, 7'h00);
		check(mon_run_o, 6'h00);
		rx_active_i = 1'b1;
		for (int c = 0; c < 4; c++) begin
			wr(SMT_ADDR_TCK, 8'(c));
			iv(SGL[c] - 1, SGL[c]);
			iv(-SGL[c], SGL[c]);
		end
		// Sum lands exactly on the limit, or one above it for the upper half of codes
		for (int k = 0; k < 8; k++) begin
			rx_active_i = 1'b0;
			step();
			rx_active_i = 1'b1;
			wr(SMT_ADDR_TCK, {1'b0, 2'(k), 3'(k), 2'b00});
			e = SUM[k] * ((k % 4) + 1) + k / 4;
			iv(e / 2, 16);
			iv(e - e / 2, 16);
			for (int j = 1; j <= 8 * ((k % 4) + 1); j++) tk({2'b00, j == 8 * ((k % 4) + 1)});
			check(baud_ok_o, k < 4);
		end
		rx_active_i = 1'b0;
		search_active_i = 1'b1;
		wakeup_search_policy_i = 1'b1;
		for (int p = 0; p < 4; p++) begin
			wr(SMT_ADDR_TO, {2'(p), 6'h01});
			pulse(search_start_i);
			for (int k = 1; k <= PRE[p]; k++) tk({k == PRE[p], k == PRE[p], 1'b0});
		end
		wr(SMT_ADDR_TO, 8'h3f);
		pulse(search_start_i);
		for (int k = 1; k <= 126; k++) tk({k == 126, k == 126, 1'b0});
		wr(SMT_ADDR_TO, 8'h00);
		pulse(search_start_i);
		repeat (130) tk(3'b000);
		all_pass_i = 1'b1;
		wr(SMT_ADDR_TO, 8'h03);
		pulse(search_start_i);
		repeat (3) tk(3'b000);
		pulse(search_start_i);
		for (int k = 1; k <= 6; k++) tk({k == 6, 2'b00});
		search_active_i = 1'b0;
		preamble_active_i = 1'b1;
		wr(SMT_ADDR_TO, 8'h01);
		pulse(preamble_start_i);
		repeat (4) tk(3'b000);
		preamble_timeout_enable_i = 1'b1;
		pulse(preamble_start_i);
		for (int k = 1; k <= 2; k++) tk({k == 2, 2'b00});
		conclude();
	end
endmodule

bind smt_signal_monitor smt_signal_monitor_checker #(.THRESH_W(THRESH_W)) smt_signal_monitor_checker_i (.*);
`default_nettype wire
